// [src/flash_bank_erase_posted_write_ctrl.sv]
// Flash bank mapping, erase triggering and deferred flash write control
`timescale 1ns/1ps
`default_nettype none
module flash_bank_erase_posted_write_ctrl
  import flash_ctrl_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire flash_ctrl_pkg::sfr_bus_t  sfr_i,
  output logic [7:0]                     sfr_rdata_o,
  input  wire flash_ctrl_pkg::xdata_wr_t xdata_i,
  input  wire logic                      int_enabled_i,
  input  wire logic                      debug_port_en_i,
  input  wire logic                      ce_enable_i,
  input  wire logic                      ce_busy_i,
  input  wire logic [15:0]               fetch_addr_i,
  output logic [16:0]                    fetch_phys_o,
  output logic                           fetch_stall_o,
  output flash_ctrl_pkg::flash_cmd_t     flash_cmd_o,
  input  wire logic                      flash_done_i,
  output logic                           deferred_write_waiting_o
);

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_ERASE = 3'b010,
    S_WRITE = 3'b100
  } seq_state_t;

  typedef struct packed {
    seq_state_t  st;
    logic        program_space_write_enable;
    logic        deferred_write_enable;
    logic        whole_erase_enable;
    logic [5:0]  erase_page_number;
    logic        page_armed;
    logic [1:0]  program_bank_select;
    logic [3:0]  modification_key;
    logic [7:0]  erase_trigger;
    flash_cmd_t  cmd;
    logic [7:0]  rdata;
    logic [16:0] fetch_phys;
    logic        stall;
  } ctrl_t;

  ctrl_t       s_q;
  ctrl_t       s_d;

  logic [16:0] fetch_map;
  logic [16:0] write_map;
  logic        key_ok;
  logic        flash_wr_try;
  logic        defer;
  logic        q_push;
  logic        q_pop;
  logic        q_pending;
  logic        drain_ready;
  flash_cmd_t  q_entry;
  flash_cmd_t  wr_cmd;
  logic        trig_wr;
  logic        page_go;
  logic        whole_go;
  logic        imm_go;
  logic        key_wr;
  logic        seq_idle;

  // Read data width follows the port, so zero padding tracks it
  localparam int unsigned SFR_DW = $bits(sfr_rdata_o);

  // Package constants must agree with the slices and widths used below
  if (PHYS_AW != LOG_AW - 1 + BANK_W) begin : g_bad_aw
    $error("flash control: physical width must be LOG_AW-1+BANK_W");
  end
  if ($bits(fetch_phys_o) != PHYS_AW) begin : g_bad_phys
    $error("flash control: fetch output width differs from PHYS_AW");
  end
  if (PAGE_LSB + PAGE_W > SFR_DW) begin : g_bad_page
    $error("flash control: page field overruns its register");
  end
  if (KEY_LSB + KEY_W > SFR_DW) begin : g_bad_key
    $error("flash control: key field overruns its byte");
  end
  if (PHYS_AW < PAGE_W) begin : g_bad_cmd
    $error("flash control: page number wider than command address");
  end

  bank_map #(
    .AW (LOG_AW),
    .BW (BANK_W),
    .PW (PHYS_AW)
  ) u_fetch_map (
    .logical_i (fetch_addr_i),
    .bank_i    (s_q.program_bank_select),
    .phys_o    (fetch_map)
  );

  bank_map #(
    .AW (LOG_AW),
    .BW (BANK_W),
    .PW (PHYS_AW)
  ) u_write_map (
    .logical_i (xdata_i.addr),
    .bank_i    (s_q.program_bank_select),
    .phys_o    (write_map)
  );

  posted_write_q #(
    .DEPTH (1)
  ) u_posted (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .push_i        (q_push),
    .push_cmd_i    (wr_cmd),
    .ce_busy_i     (ce_busy_i),
    .drain_ready_i (drain_ready),
    .pending_o     (q_pending),
    .pop_o         (q_pop),
    .entry_o       (q_entry)
  );

  // Every modification, erase or write, is gated by the key
  assign key_ok       = (s_q.modification_key == KEY_OPEN);
  assign flash_wr_try = xdata_i.wr && s_q.program_space_write_enable;
  assign trig_wr      = sfr_i.wr && (sfr_i.addr == SFR_ERASE_TRIGGER);
  // Any command under way means the array is busy
  assign seq_idle     = (s_q.st == S_IDLE);
  // Only the two patterns do anything; idle check holds off commands mid-erase
  assign page_go      = trig_wr && (sfr_i.wdata == ERASE_PAGE_PAT) && key_ok
                        && s_q.page_armed && seq_idle;
  assign whole_go     = trig_wr && (sfr_i.wdata == ERASE_WHOLE_PAT) && key_ok
                        && s_q.whole_erase_enable && debug_port_en_i
                        && seq_idle;
  // Deferral only when both enables are set
  assign defer        = s_q.deferred_write_enable && ce_enable_i;
  // A full slot refuses the push, so the extra write is dropped
  assign q_push       = flash_wr_try && key_ok && defer && !q_pending;
  // A held entry also blocks immediate writes, so none overtakes it
  assign imm_go       = flash_wr_try && key_ok && !defer && !q_pending && seq_idle;
  // Held entry yields to any fresh command that claims the sequencer this cycle
  assign drain_ready  = seq_idle && !page_go && !whole_go && !imm_go;

  // Key lives in I/O RAM, reached by ordinary data writes
  assign key_wr       = xdata_i.wr && !s_q.program_space_write_enable
                        && (xdata_i.addr == IO_KEY_ADDR);

  always_comb begin
    wr_cmd       = '0;
    wr_cmd.valid = 1'b1;
    wr_cmd.op    = OP_WRITE;
    wr_cmd.addr  = write_map;
    wr_cmd.data  = xdata_i.wdata;
  end

  always_comb begin
    s_d           = s_q;
    s_d.cmd.valid = 1'b0;
    s_d.rdata     = s_q.rdata;

    // Trigger value is never kept; the register reads back nothing
    s_d.erase_trigger = ERASE_TRIGGER_RST;

    if (sfr_i.wr) begin
      case (sfr_i.addr)
        SFR_FLASH_CTRL: begin
          // Interrupt-enabled software may not arm byte writes
          if (!int_enabled_i) begin
            s_d.program_space_write_enable = sfr_i.wdata[PWE_BIT];
          end
          s_d.whole_erase_enable    = sfr_i.wdata[MEEN_BIT];
          s_d.deferred_write_enable = sfr_i.wdata[PSTWR_BIT];
          // Pending flag is read-only; its bit in a write is dropped
        end
        SFR_BANK_SELECT: begin
          s_d.program_bank_select = sfr_i.wdata[BANK_W-1:0];
        end
        SFR_PAGE_NUMBER: begin
          s_d.erase_page_number = sfr_i.wdata[PAGE_LSB +: PAGE_W];
          s_d.page_armed        = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Key is write-only from here; nothing reads it back
    if (key_wr) begin
      s_d.modification_key = xdata_i.wdata[KEY_LSB +: KEY_W];
    end

    // Write enable is spent by each byte, even a refused one
    if (flash_wr_try) begin
      s_d.program_space_write_enable = 1'b0;
    end

    // Erase beats immediate write beats held entry; one command outstanding
    case (s_q.st)
      S_IDLE: begin
        if (page_go) begin
          s_d.cmd.valid  = 1'b1;
          s_d.cmd.op     = OP_PAGE_ERASE;
          s_d.cmd.addr   = {{(PHYS_AW-PAGE_W){1'b0}}, s_q.erase_page_number};
          s_d.cmd.data   = '0;
          s_d.page_armed = 1'b0;
          s_d.st         = S_ERASE;
        end else if (whole_go) begin
          s_d.cmd.valid          = 1'b1;
          s_d.cmd.op             = OP_WHOLE_ERASE;
          s_d.cmd.addr           = '0;
          s_d.cmd.data           = '0;
          s_d.whole_erase_enable = 1'b0;
          s_d.st                 = S_ERASE;
        end else if (imm_go) begin
          s_d.cmd = wr_cmd;
          s_d.st  = S_WRITE;
        end else if (q_pop) begin
          s_d.cmd = q_entry;
          s_d.st  = S_WRITE;
        end
      end
      S_ERASE: begin
        // Fetch stall and command hold-off last until the array reports done
        if (flash_done_i) begin
          s_d.st = S_IDLE;
        end
      end
      S_WRITE: begin
        // A byte write holds the array the same way
        if (flash_done_i) begin
          s_d.st = S_IDLE;
        end
      end
      default: begin
        s_d.st = S_IDLE;
      end
    endcase

    // A fresh page number written in the same cycle as the erase still arms
    if (sfr_i.wr && (sfr_i.addr == SFR_PAGE_NUMBER) && page_go) begin
      s_d.page_armed = 1'b1;
    end

    if (sfr_i.rd) begin
      case (sfr_i.addr)
        SFR_FLASH_CTRL: begin
          // Whole-erase enable is write-only and reads as zero
          s_d.rdata            = '0;
          s_d.rdata[PWE_BIT]   = s_q.program_space_write_enable;
          s_d.rdata[PSTWR_BIT] = s_q.deferred_write_enable;
          s_d.rdata[PEND_BIT]  = q_pending;
        end
        SFR_BANK_SELECT: begin
          s_d.rdata = {{(SFR_DW-BANK_W){1'b0}}, s_q.program_bank_select};
        end
        default: begin
          // Write-only and unmapped locations read as zero
          s_d.rdata = '0;
        end
      endcase
    end

    // Registered so the output comes from a flop; costs one cycle of latency
    s_d.fetch_phys = fetch_map;
    // Fetch stall follows the sequencer so no fetch meets a busy array
    s_d.stall = (s_d.st != S_IDLE);
  end

  always_ff @(posedge clk_i) begin
    // Bank one after reset gives plain linear addressing
    if (rst_i) begin
      s_q                     <= '0;
      s_q.st                  <= S_IDLE;
      s_q.program_bank_select <= BANK_SELECT_RST;
      s_q.erase_page_number   <= PAGE_NUMBER_RST;
      s_q.modification_key    <= KEY_RST;
      s_q.erase_trigger       <= ERASE_TRIGGER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata_o              = s_q.rdata;
  assign fetch_phys_o             = s_q.fetch_phys;
  assign fetch_stall_o            = s_q.stall;
  assign flash_cmd_o              = s_q.cmd;
  assign deferred_write_waiting_o = q_pending;

endmodule // flash_bank_erase_posted_write_ctrl
`default_nettype wire

// [src/flash_ctrl_pkg.sv]
// Shared constants and carrier types for the flash bank, erase and deferred write control
`default_nettype none
package flash_ctrl_pkg;

  // Special-function register addresses
  localparam logic [7:0]  SFR_ERASE_TRIGGER = 8'h94;
  localparam logic [7:0]  SFR_FLASH_CTRL    = 8'hB2;
  localparam logic [7:0]  SFR_BANK_SELECT   = 8'hB6;
  localparam logic [7:0]  SFR_PAGE_NUMBER   = 8'hB7;

  // Field positions inside the flash control, page number and bank select registers
  localparam int unsigned PWE_BIT   = 0;
  localparam int unsigned MEEN_BIT  = 1;
  localparam int unsigned PSTWR_BIT = 2;
  localparam int unsigned PEND_BIT  = 3;
  localparam int unsigned PAGE_LSB  = 2;
  localparam int unsigned PAGE_W    = 6;
  localparam int unsigned BANK_W    = 2;

  // Modification key in I/O RAM, upper nibble
  localparam logic [15:0] IO_KEY_ADDR = 16'h2702;
  localparam int unsigned KEY_LSB     = 4;
  localparam int unsigned KEY_W       = 4;
  localparam logic [3:0]  KEY_OPEN    = 4'h2;

  // Erase trigger patterns
  localparam logic [7:0]  ERASE_PAGE_PAT  = 8'h55;
  localparam logic [7:0]  ERASE_WHOLE_PAT = 8'hAA;

  // Reset values
  localparam logic [7:0]  ERASE_TRIGGER_RST = 8'h00;
  localparam logic [1:0]  BANK_SELECT_RST   = 2'h1;
  localparam logic [5:0]  PAGE_NUMBER_RST   = 6'h00;
  localparam logic [3:0]  KEY_RST           = 4'h0;

  // Address widths: 64 KB logical space, four 32 KB physical banks
  localparam int unsigned LOG_AW  = 16;
  localparam int unsigned PHYS_AW = 17;

  typedef enum logic [1:0] {
    OP_WRITE       = 2'h0,
    OP_PAGE_ERASE  = 2'h1,
    OP_WHOLE_ERASE = 2'h2
  } flash_op_t;

  typedef struct packed {
    logic              valid;
    flash_op_t         op;
    logic [16:0]       addr;
    logic [7:0]        data;
  } flash_cmd_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [7:0]        addr;
    logic [7:0]        wdata;
  } sfr_bus_t;

  typedef struct packed {
    logic              wr;
    logic [15:0]       addr;
    logic [7:0]        wdata;
  } xdata_wr_t;

endpackage
`default_nettype wire

// [src/bank_map.sv]
// Logical program address to physical flash address translation
`timescale 1ns/1ps
`default_nettype none
module bank_map #(
  parameter int unsigned AW = 16,
  parameter int unsigned BW = 2,
  parameter int unsigned PW = 17
) (
  input  wire logic [AW-1:0] logical_i,
  input  wire logic [BW-1:0] bank_i,
  output logic      [PW-1:0] phys_o
);
  if (PW != AW - 1 + BW) begin : g_bad_width
    $error("bank_map: PW must equal AW-1+BW");
  end

  always_comb begin
    // Lower window never follows the bank field
    phys_o = {{BW{1'b0}}, logical_i[AW-2:0]};
    // Upper window: bank times window size plus offset; bank 0 aliases lower
    if (logical_i[AW-1]) begin
      phys_o = {bank_i, logical_i[AW-2:0]};
    end
  end
endmodule // bank_map
`default_nettype wire

// [src/posted_write_q.sv]
// One-entry holding slot for flash writes deferred until the compute engine goes idle
`timescale 1ns/1ps
`default_nettype none
module posted_write_q
  import flash_ctrl_pkg::*;
#(
  parameter int unsigned DEPTH = 1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        push_i,
  input  wire flash_ctrl_pkg::flash_cmd_t push_cmd_i,
  input  wire logic        ce_busy_i,
  input  wire logic        drain_ready_i,
  output logic             pending_o,
  output logic             pop_o,
  output flash_ctrl_pkg::flash_cmd_t entry_o
);
  if (DEPTH != 1) begin : g_bad_depth
    $error("posted_write_q: only a single entry is supported");
  end

  typedef struct packed {
    logic       full;
    logic       busy_prev;
    logic       fell;
    flash_cmd_t entry;
  } q_state_t;

  q_state_t q_q;
  q_state_t q_d;
  logic     fall_now;

  assign pending_o = q_q.full;
  assign entry_o   = q_q.entry;
  assign fall_now  = q_q.busy_prev && !ce_busy_i;
  // Fall seen while the sequencer was busy is remembered, not lost
  assign pop_o     = q_q.full && (q_q.fell || fall_now) && drain_ready_i;

  always_comb begin
    q_d           = q_q;
    q_d.busy_prev = ce_busy_i;
    if (q_q.full && fall_now) begin
      q_d.fell = 1'b1;
    end
    if (pop_o) begin
      q_d.full = 1'b0;
      q_d.fell = 1'b0;
    end else if (push_i && !q_q.full) begin
      q_d.full  = 1'b1;
      q_d.fell  = 1'b0;
      q_d.entry = push_cmd_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_q <= '0;
    end else begin
      q_q <= q_d;
    end
  end
endmodule // posted_write_q
`default_nettype wire

// [verification/flash_ctrl_properties.sv]
// Concurrent checks on the flash control block ports
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_checker
  import flash_ctrl_pkg::*;
(
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire flash_ctrl_pkg::sfr_bus_t   sfr_i,
  input wire logic                       debug_port_en_i,
  input wire logic                       ce_busy_i,
  input wire logic [15:0]                fetch_addr_i,
  input wire logic [16:0]                fetch_phys_o,
  input wire logic                       fetch_stall_o,
  input wire flash_ctrl_pkg::flash_cmd_t flash_cmd_o,
  input wire logic                       flash_done_i,
  input wire logic                       deferred_write_waiting_o
);
  logic [1:0] bank_q;
  logic [5:0] page_q;
  logic       trig_wr;

  assign trig_wr = sfr_i.wr && sfr_i.addr == SFR_ERASE_TRIGGER;

  // Shadows of the bank and page fields, updated like the design's
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_q <= BANK_SELECT_RST;
      page_q <= PAGE_NUMBER_RST;
    end else if (sfr_i.wr && sfr_i.addr == SFR_BANK_SELECT) begin
      bank_q <= sfr_i.wdata[1:0];
    end else if (sfr_i.wr && sfr_i.addr == SFR_PAGE_NUMBER) begin
      page_q <= sfr_i.wdata[7:2];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  lower_window_a: assert property (!fetch_addr_i[15] |=>
    fetch_phys_o == {2'b00, $past(fetch_addr_i[14:0])}) else $error("lower map wrong");
  upper_window_a: assert property (fetch_addr_i[15] |=>
    fetch_phys_o == {$past(bank_q), $past(fetch_addr_i[14:0])}) else $error("upper map wrong");
  page_cause_a: assert property (flash_cmd_o.valid && flash_cmd_o.op == OP_PAGE_ERASE |->
    $past(trig_wr && sfr_i.wdata == ERASE_PAGE_PAT)) else $error("page erase uncaused");
  page_number_a: assert property (flash_cmd_o.valid && flash_cmd_o.op == OP_PAGE_ERASE |->
    flash_cmd_o.addr == {11'h000, page_q}) else $error("page number wrong");
  whole_cause_a: assert property (flash_cmd_o.valid && flash_cmd_o.op == OP_WHOLE_ERASE |->
    $past(trig_wr && sfr_i.wdata == ERASE_WHOLE_PAT && debug_port_en_i))
    else $error("whole erase uncaused");
  cmd_pulse_a: assert property (flash_cmd_o.valid |->
    fetch_stall_o ##1 !flash_cmd_o.valid) else $error("command pulse wrong");
  stall_hold_a: assert property (fetch_stall_o && !flash_done_i |=> fetch_stall_o)
    else $error("stall dropped early");
  held_write_a: assert property (deferred_write_waiting_o && ce_busy_i |=>
    deferred_write_waiting_o && !flash_cmd_o.valid) else $error("held write released early");
endmodule // flash_ctrl_checker

bind flash_bank_erase_posted_write_ctrl flash_ctrl_checker u_chk (.clk_i, .rst_i, .sfr_i,
  .debug_port_en_i, .ce_busy_i, .fetch_addr_i, .fetch_phys_o, .fetch_stall_o, .flash_cmd_o,
  .flash_done_i, .deferred_write_waiting_o);
`default_nettype wire

// [verification/flash_array_model.sv]
// Behavioural flash array answering each command after a set latency
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
  import flash_ctrl_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire flash_ctrl_pkg::flash_cmd_t cmd_i,
  input  wire logic [4:0]                 lat_i,
  output logic                            done_o
);
  logic [4:0] cnt_q;
  logic       busy_q;
  // Done never comes in the command's own cycle
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      busy_q <= 1'b0;
      cnt_q  <= 5'h00;
    end else if (cmd_i.valid) begin
      busy_q <= 1'b1;
      cnt_q  <= lat_i;
    end else if (busy_q && cnt_q == 5'h00) begin
      busy_q <= 1'b0;
      done_o <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule // flash_array_model
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the flash control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flash_ctrl_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  sfr_bus_t    sfr_i = '0;
  xdata_wr_t   xdata_i = '0;
  logic        int_en = 1'b0;
  logic        dbg = 1'b0;
  logic        ce_en = 1'b0;
  logic        ce_busy = 1'b0;
  logic [15:0] fetch = 16'h0000;
  logic [4:0]  lat = 5'h01;
  logic [7:0]  rdata, r, d;
  logic [16:0] phys;
  logic        stall, done, waiting;
  flash_cmd_t  cmd, last;
  logic [15:0] a;
  logic [5:0]  pg;
  int          err_count = 0;
  int          checks = 0;
  int          ncmd = 0;
  int          n0 = 0;

  flash_bank_erase_posted_write_ctrl dut (.clk_i, .rst_i, .sfr_i, .sfr_rdata_o(rdata),
    .xdata_i, .int_enabled_i(int_en), .debug_port_en_i(dbg), .ce_enable_i(ce_en),
    .ce_busy_i(ce_busy), .fetch_addr_i(fetch), .fetch_phys_o(phys), .fetch_stall_o(stall),
    .flash_cmd_o(cmd), .flash_done_i(done), .deferred_write_waiting_o(waiting));
  flash_array_model u_flash (.clk_i, .rst_i, .cmd_i(cmd), .lat_i(lat), .done_o(done));

  initial forever #10 clk_i = ~clk_i;

  always @(posedge clk_i) if (cmd.valid === 1'b1) begin
    ncmd <= ncmd + 1;
    last <= cmd;
  end

  function automatic logic [16:0] exp_phys(input logic [15:0] ad, input logic [1:0] b);
    return ad[15] ? {b, ad[14:0]} : {2'b00, ad[14:0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk_i);
    sfr_i <= '{1'b0, 1'b1, ad, dt};
    @(posedge clk_i);
    sfr_i.wr <= 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] ad, output logic [7:0] q);
    @(posedge clk_i);
    sfr_i <= '{1'b1, 1'b0, ad, 8'h00};
    @(posedge clk_i);
    sfr_i.rd <= 1'b0;
    #1 q = rdata;
  endtask

  task automatic xd_wr(input logic [15:0] ad, input logic [7:0] dt);
    @(posedge clk_i);
    xdata_i <= '{1'b1, ad, dt};
    @(posedge clk_i);
    xdata_i.wr <= 1'b0;
  endtask

  // Waits for the array to finish, then compares commands seen since the last call
  task automatic expect_cmd(input int dn, input logic [1:0] op, input logic [16:0] ad,
                            input logic [7:0] dt);
    int k;
    k = 0;
    repeat (4) @(posedge clk_i);
    #1;
    while (stall !== 1'b0 && k < 100) begin
      @(posedge clk_i);
      #1 k++;
    end
    if (k == 100) begin
      err_count++;
      final_report();
    end
    chk("cmd count", 32'(ncmd - n0), 32'(dn));
    if (dn > 0) chk("op", last.op, op);
    if (dn > 0 && op != OP_WHOLE_ERASE) chk("addr", last.addr, ad);
    if (dn > 0 && op == OP_WRITE) chk("data", last.data, dt);
    n0 = ncmd;
  endtask

  initial begin
    void'($urandom(31249));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 chk("reset outs", {rdata, phys, stall, waiting, cmd.valid}, 32'h0000_0000);
    sfr_rd(SFR_BANK_SELECT, r);
    chk("bank reset", r, 8'h01);
    sfr_wr(SFR_PAGE_NUMBER, 8'h04);
    sfr_wr(SFR_ERASE_TRIGGER, ERASE_PAGE_PAT);
    expect_cmd(0, OP_PAGE_ERASE, 17'h0_0001, 8'h00);
    xd_wr(IO_KEY_ADDR, {KEY_OPEN, 4'h0});
    for (int b = 0; b < 4; b++) begin
      sfr_wr(SFR_BANK_SELECT, 8'(b));
      sfr_rd(SFR_BANK_SELECT, r);
      chk("bank", r, 8'(b));
      for (int j = 0; j < 4; j++) begin
        // Window edges first, then random addresses
        a = (j == 0) ? 16'h7fff : (j == 1) ? 16'h8000 : 16'($urandom);
        @(posedge clk_i);
        fetch <= a;
        @(posedge clk_i);
        #1 chk("fetch map", phys, exp_phys(a, 2'(b)));
      end
    end
    for (int i = 0; i < 3; i++) begin
      pg = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
      lat <= 5'($urandom);
      sfr_wr(SFR_PAGE_NUMBER, {pg, 2'b00});
      sfr_wr(SFR_ERASE_TRIGGER, ERASE_PAGE_PAT);
      expect_cmd(1, OP_PAGE_ERASE, {11'h000, pg}, 8'h00);
    end
    sfr_wr(SFR_ERASE_TRIGGER, ERASE_PAGE_PAT);
    expect_cmd(0, OP_PAGE_ERASE, 17'h0_0000, 8'h00);
    sfr_wr(SFR_PAGE_NUMBER, 8'h08);
    repeat (4) begin
      d = 8'($urandom);
      sfr_wr(SFR_ERASE_TRIGGER, (d == 8'h55 || d == 8'haa) ? 8'h00 : d);
    end
    expect_cmd(0, OP_PAGE_ERASE, 17'h0_0002, 8'h00);
    sfr_wr(SFR_ERASE_TRIGGER, ERASE_PAGE_PAT);
    expect_cmd(1, OP_PAGE_ERASE, 17'h0_0002, 8'h00);
    @(posedge clk_i);
    dbg <= 1'b1;
    sfr_wr(SFR_ERASE_TRIGGER, ERASE_WHOLE_PAT);
    expect_cmd(0, OP_WHOLE_ERASE, 17'h0_0000, 8'h00);
    sfr_wr(SFR_FLASH_CTRL, 8'h02);
    sfr_rd(SFR_FLASH_CTRL, r);
    chk("enable reads zero", r[1], 1'b0);
    @(posedge clk_i);
    dbg <= 1'b0;
    sfr_wr(SFR_ERASE_TRIGGER, ERASE_WHOLE_PAT);
    expect_cmd(0, OP_WHOLE_ERASE, 17'h0_0000, 8'h00);
    @(posedge clk_i);
    dbg <= 1'b1;
    sfr_wr(SFR_ERASE_TRIGGER, ERASE_WHOLE_PAT);
    expect_cmd(1, OP_WHOLE_ERASE, 17'h0_0000, 8'h00);
    sfr_wr(SFR_ERASE_TRIGGER, ERASE_WHOLE_PAT);
    expect_cmd(0, OP_WHOLE_ERASE, 17'h0_0000, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      ce_en <= i[1];
      ce_busy <= 1'b1;
      sfr_wr(SFR_FLASH_CTRL, {5'h00, i[0], 2'b01});
      a = 16'($urandom);
      d = 8'($urandom);
      xd_wr(a, d);
      if (i == 3) begin
        sfr_rd(SFR_FLASH_CTRL, r);
        chk("pending", r[3], 1'b1);
        chk("waiting out", waiting, 1'b1);
        sfr_wr(SFR_FLASH_CTRL, 8'h05);
        xd_wr(~a, ~d);
        // An immediate write must not overtake the held entry either
        sfr_wr(SFR_FLASH_CTRL, 8'h01);
        xd_wr(a ^ 16'h0001, d);
        expect_cmd(0, OP_WRITE, 17'h0_0000, 8'h00);
        @(posedge clk_i);
        ce_busy <= 1'b0;
      end
      expect_cmd(1, OP_WRITE, exp_phys(a, 2'h3), d);
      chk("waiting out", waiting, 1'b0);
      sfr_rd(SFR_FLASH_CTRL, r);
      chk("write enable", r[0], 1'b0);
    end
    @(posedge clk_i);
    int_en <= 1'b1;
    sfr_wr(SFR_FLASH_CTRL, 8'h01);
    sfr_rd(SFR_FLASH_CTRL, r);
    chk("locked enable", r[0], 1'b0);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
